// >>> core/fdp_params.svh
// Offsets, reset values, write masks and widths of the divider bank.
// How it works
// - Each reference pre-divider is ten bits, ratio 1..1023.
// - Second loop integer divider: 32 bits, reset 0xFBA.
// - Role bit 0: analog loop is system loop oscillator.
// - Role bit 1 (reset): standalone synthesizer, system loop off.
// - Modulator off: analog feedback divides by integer only.
// - Modulator on (reset): integer plus numerator over denominator.
// - Analog integer divider resets to 0x31.
`ifndef FDP_PARAMS_SVH
`define FDP_PARAMS_SVH

`define FDP_ADDR_W 16
`define FDP_NREG 29
`define FDP_PREDIV_W 10

`define FDP_OFF_REF0_LO 16'h01E0
`define FDP_OFF_REF0_HI 16'h01E1
`define FDP_OFF_SECOND_REFERENCE_LO 16'h01E2
`define FDP_OFF_SECOND_REFERENCE_HI 16'h01E3
`define FDP_OFF_L1INT_B0 16'h01E4
`define FDP_OFF_L1INT_B1 16'h01E5
`define FDP_OFF_L1INT_B2 16'h01E6
`define FDP_OFF_L1INT_B3 16'h01E7
`define FDP_OFF_L1NUM_B0 16'h01E9
`define FDP_OFF_L1NUM_B1 16'h01EA
`define FDP_OFF_L1NUM_B2 16'h01EB
`define FDP_OFF_L1DEN_B0 16'h01EC
`define FDP_OFF_L1DEN_B1 16'h01ED
`define FDP_OFF_L1DEN_B2 16'h01EE
`define FDP_OFF_AINT 16'h0200
`define FDP_OFF_AMODE 16'h0201
`define FDP_OFF_ACALREF 16'h0202
`define FDP_OFF_ACALCTL 16'h0203
`define FDP_OFF_ANUM_B0 16'h0204
`define FDP_OFF_ANUM_B1 16'h0205
`define FDP_OFF_ANUM_B2 16'h0206
`define FDP_OFF_ADEN_B0 16'h0208
`define FDP_OFF_ADEN_B1 16'h0209
`define FDP_OFF_ADEN_B2 16'h020A
`define FDP_OFF_AMOD 16'h020C
`define FDP_OFF_APOFS 16'h020D
`define FDP_OFF_APCORE 16'h020E
`define FDP_OFF_APDIR 16'h020F
`define FDP_OFF_APD 16'h0210

`define FDP_RST_REF_LO 8'h00
`define FDP_RST_REF_HI 8'h00
`define FDP_RST_L1INT 32'h0000_0FBA
`define FDP_RST_L1NUM 24'h33_F000
`define FDP_RST_L1DEN 24'h61_A800
`define FDP_RST_AINT 8'h31
`define FDP_RST_AMODE 8'hC0
`define FDP_RST_ACALREF 8'h75
`define FDP_RST_ACALCTL 8'h06
`define FDP_RST_ANUM 24'h43_0000
`define FDP_RST_ADEN 24'h7D_0000
`define FDP_RST_AMOD 8'h06
`define FDP_RST_APOFS 8'h80
`define FDP_RST_APCORE 8'h0F
`define FDP_RST_APDIR 8'hF0
`define FDP_RST_APD 8'h00

`define FDP_WM_FULL 8'hFF
`define FDP_WM_REF_HI 8'h03
`define FDP_WM_AMODE 8'hC0
`define FDP_WM_ACALCTL 8'hBF
`define FDP_WM_AMOD 8'h7E
`define FDP_WM_APOFS 8'hBF
`define FDP_WM_APD 8'hF0

`define FDP_BIT_MOD_EN 7
`define FDP_BIT_ROLE 6
`define FDP_ROLE_OSC 1'b0

`endif

// >>> core/fdp_pkg.sv
// Types shared by the divider bank and its users.
package fdp_pkg;

  typedef logic [7:0] fdp_byte_t;

  typedef struct packed {
    logic [9:0] ref0_prediv;
    logic [9:0] second_reference_prediv;
    logic [31:0] loop1_fb_integer;
    logic [23:0] loop1_fb_numer;
    logic [23:0] loop1_fb_denom;
  } fdp_loop1_cfg_s;

  typedef struct packed {
    logic [7:0] analog_integer_div;
    logic [23:0] analog_numer;
    logic [23:0] analog_denom;
    logic fractional_modulator_enable;
    logic analog_role_select;
  } fdp_analog_cfg_s;

  typedef struct packed {
    logic [7:0] integer_div;
    logic [23:0] numer;
    logic [23:0] denom;
  } fdp_feedback_s;

endpackage : fdp_pkg

// >>> core/fdp_reg8.sv
// One byte of the bank with its reset value and writable-bit mask.
`timescale 1ns/1ns
`include "fdp_params.svh"
module fdp_reg8
  import fdp_pkg::*;
#(
  parameter fdp_byte_t RST_VAL = 8'h00,
  parameter fdp_byte_t WR_MASK = 8'hFF
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_hit,
  input wire fdp_byte_t wr_data,
  output fdp_byte_t q_ff
);

  // Bits outside the mask are reserved; they hold zero and read as zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff <= RST_VAL & WR_MASK;
    end
    else if (wr_hit)
    begin
      q_ff <= wr_data & WR_MASK;
    end
  end

endmodule : fdp_reg8

// >>> core/fdp_config_bank.sv
// Divider configuration bank for the second digital loop and analog loop.
`timescale 1ns/1ns
`include "fdp_params.svh"
module fdp_config_bank
  import fdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire fdp_byte_t reg_wdata,
  input wire logic reg_rd,
  output fdp_byte_t reg_rdata_ff,
  output logic reg_rvalid_ff,
  output logic reg_hit_ff,
  output fdp_loop1_cfg_s loop1_cfg_ff,
  output fdp_analog_cfg_s analog_cfg_ff,
  output fdp_feedback_s analog_fb_ff,
  output logic sys_loop_dco_sel_ff,
  output logic synth_standalone_ff,
  output logic sys_loop_enable_ff,
  output logic prediv_range_err_ff,
  output logic role_mode_conflict_ff,
  output fdp_byte_t [6:0] analog_aux_ff
);

  localparam int NREG = `FDP_NREG;

  localparam logic [NREG-1:0][15:0] OFFS = {
    `FDP_OFF_APD, `FDP_OFF_APDIR, `FDP_OFF_APCORE, `FDP_OFF_APOFS,
    `FDP_OFF_AMOD, `FDP_OFF_ADEN_B2, `FDP_OFF_ADEN_B1, `FDP_OFF_ADEN_B0,
    `FDP_OFF_ANUM_B2, `FDP_OFF_ANUM_B1, `FDP_OFF_ANUM_B0,
    `FDP_OFF_ACALCTL, `FDP_OFF_ACALREF, `FDP_OFF_AMODE, `FDP_OFF_AINT,
    `FDP_OFF_L1DEN_B2, `FDP_OFF_L1DEN_B1, `FDP_OFF_L1DEN_B0,
    `FDP_OFF_L1NUM_B2, `FDP_OFF_L1NUM_B1, `FDP_OFF_L1NUM_B0,
    `FDP_OFF_L1INT_B3, `FDP_OFF_L1INT_B2, `FDP_OFF_L1INT_B1,
    `FDP_OFF_L1INT_B0,
    `FDP_OFF_SECOND_REFERENCE_HI, `FDP_OFF_SECOND_REFERENCE_LO, `FDP_OFF_REF0_HI, `FDP_OFF_REF0_LO
  };

  localparam logic [31:0] L1INT = `FDP_RST_L1INT;
  localparam logic [23:0] L1NUM = `FDP_RST_L1NUM;
  localparam logic [23:0] L1DEN = `FDP_RST_L1DEN;
  localparam logic [23:0] ANUM = `FDP_RST_ANUM;
  localparam logic [23:0] ADEN = `FDP_RST_ADEN;

  // Multi-byte fields: least significant byte at the lowest offset.
  localparam logic [NREG-1:0][7:0] RSTV = {
    `FDP_RST_APD, `FDP_RST_APDIR, `FDP_RST_APCORE, `FDP_RST_APOFS,
    `FDP_RST_AMOD, ADEN[23:16], ADEN[15:8], ADEN[7:0],
    ANUM[23:16], ANUM[15:8], ANUM[7:0],
    `FDP_RST_ACALCTL, `FDP_RST_ACALREF, `FDP_RST_AMODE,
    `FDP_RST_AINT,
    L1DEN[23:16], L1DEN[15:8], L1DEN[7:0],
    L1NUM[23:16], L1NUM[15:8], L1NUM[7:0],
    L1INT[31:24], L1INT[23:16], L1INT[15:8], L1INT[7:0],
    `FDP_RST_REF_HI, `FDP_RST_REF_LO, `FDP_RST_REF_HI, `FDP_RST_REF_LO
  };

  localparam logic [NREG-1:0][7:0] WMSK = {
    `FDP_WM_APD, `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_APOFS,
    `FDP_WM_AMOD, `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL,
    `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL,
    `FDP_WM_ACALCTL, `FDP_WM_FULL, `FDP_WM_AMODE, `FDP_WM_FULL,
    `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL,
    `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL,
    `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL, `FDP_WM_FULL,
    `FDP_WM_REF_HI, `FDP_WM_FULL, `FDP_WM_REF_HI, `FDP_WM_FULL
  };

  fdp_byte_t bank_q [NREG];
  logic [NREG-1:0] addr_hit;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      assign addr_hit[gi] = (reg_addr == OFFS[gi]);
      fdp_reg8 #(
        .RST_VAL(RSTV[gi]),
        .WR_MASK(WMSK[gi])
      ) u_reg (
        .clk(clk),
        .rst_n(rst_n),
        .wr_hit(reg_wr && addr_hit[gi]),
        .wr_data(reg_wdata),
        .q_ff(bank_q[gi])
      );
    end
  endgenerate

  fdp_byte_t nxt_rdata;

  always_comb
  begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < NREG; i++)
    begin
      if (addr_hit[i])
      begin
        nxt_rdata = bank_q[i];
      end
    end
  end

  // Read answer one cycle after the request; unmapped offsets read zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_rd;
    end
  end

  // A hit answers both reads and writes to a mapped offset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_hit_ff <= 1'b0;
    end
    else
    begin
      reg_hit_ff <= (reg_rd || reg_wr) && (|addr_hit);
    end
  end

  // Read data hold until the next read. A read and a write to one offset
  // in the same cycle return the byte as it was before the write.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // Assembled fields from the byte array.
  fdp_loop1_cfg_s nxt_loop1;
  fdp_analog_cfg_s nxt_analog;
  fdp_feedback_s nxt_fb;
  logic mod_en;
  logic role;

  // The mode byte carries the modulator enable and the role select; it
  // sits just above the analog integer divider in the bank.
  localparam int IDX_AMODE = 15;

  assign mod_en = bank_q[IDX_AMODE][`FDP_BIT_MOD_EN];
  assign role = bank_q[IDX_AMODE][`FDP_BIT_ROLE];

  always_comb
  begin
    nxt_loop1.ref0_prediv = {bank_q[1][1:0], bank_q[0]};
    nxt_loop1.second_reference_prediv = {bank_q[3][1:0], bank_q[2]};
    nxt_loop1.loop1_fb_integer = {bank_q[7], bank_q[6], bank_q[5],
                                  bank_q[4]};
    nxt_loop1.loop1_fb_numer = {bank_q[10], bank_q[9], bank_q[8]};
    // Fields follow the bank byte by byte with no shadow copy, so a field
    // shows a mix of old and new bytes until software has written them all.
    nxt_loop1.loop1_fb_denom = {bank_q[13], bank_q[12], bank_q[11]};
    nxt_analog.analog_integer_div = bank_q[14];
    nxt_analog.analog_numer = {bank_q[20], bank_q[19], bank_q[18]};
    nxt_analog.analog_denom = {bank_q[23], bank_q[22], bank_q[21]};
    nxt_analog.fractional_modulator_enable = mod_en;
    nxt_analog.analog_role_select = role;
    // Integer mode drops the fraction; fractional mode passes it on.
    nxt_fb.integer_div = bank_q[14];
    nxt_fb.numer = mod_en ? nxt_analog.analog_numer : 24'h00_0000;
    nxt_fb.denom = mod_en ? nxt_analog.analog_denom : 24'h00_0000;
  end

  // Second loop fields, one register copy of the bank bytes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loop1_cfg_ff <= '0;
    end
    else
    begin
      loop1_cfg_ff <= nxt_loop1;
    end
  end

  // Analog loop fields exactly as stored.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_cfg_ff <= '0;
    end
    else
    begin
      analog_cfg_ff <= nxt_analog;
    end
  end

  // Feedback the analog loop really uses. Integer mode zeroes the fraction
  // so that no stale numerator or denominator reaches the divider.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_fb_ff <= '0;
    end
    else
    begin
      analog_fb_ff <= nxt_fb;
    end
  end

  // Oscillator role: the analog loop serves the system loop.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_loop_dco_sel_ff <= 1'b0;
    end
    else
    begin
      sys_loop_dco_sel_ff <= (role == `FDP_ROLE_OSC);
    end
  end

  // Standalone role, the reset choice: the analog loop is a synthesizer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synth_standalone_ff <= 1'b0;
    end
    else
    begin
      synth_standalone_ff <= (role != `FDP_ROLE_OSC);
    end
  end

  // The system loop can only run while the analog loop is its oscillator.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_loop_enable_ff <= 1'b0;
    end
    else
    begin
      sys_loop_enable_ff <= (role == `FDP_ROLE_OSC);
    end
  end

  // A zero pre-divider is stored as written and only flagged here;
  // keeping the ratio in range is left to software.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prediv_range_err_ff <= 1'b0;
    end
    else
    begin
      prediv_range_err_ff <= (nxt_loop1.ref0_prediv == 10'h000) ||
                             (nxt_loop1.second_reference_prediv == 10'h000);
    end
  end

  // Integer mode in the oscillator role is not refused, only flagged,
  // so that software sees the setting it must avoid.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      role_mode_conflict_ff <= 1'b0;
    end
    else
    begin
      role_mode_conflict_ff <= (role == `FDP_ROLE_OSC) && !mod_en;
    end
  end

  // Calibration, modulator, pump and power-down bytes passed out as stored.
  // Element 0 holds the low calibration byte, element 6 the power-down byte.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      analog_aux_ff <= '0;
    end
    else
    begin
      analog_aux_ff <= {bank_q[28], bank_q[27], bank_q[26], bank_q[25],
                        bank_q[24], bank_q[17], bank_q[16]};
    end
  end

endmodule : fdp_config_bank

// >>> tb/fdp_config_bank_monitor.sv
// Port assertions for the divider configuration bank.
`timescale 1ns/1ns
module fdp_config_bank_monitor
  import fdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire fdp_byte_t reg_wdata,
  input wire logic reg_rd,
  input wire fdp_byte_t reg_rdata_ff,
  input wire logic reg_rvalid_ff,
  input wire logic reg_hit_ff,
  input wire fdp_loop1_cfg_s loop1_cfg_ff,
  input wire fdp_analog_cfg_s analog_cfg_ff,
  input wire fdp_feedback_s analog_fb_ff,
  input wire logic sys_loop_dco_sel_ff,
  input wire logic synth_standalone_ff,
  input wire logic sys_loop_enable_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence mode_wr;
    reg_wr && reg_addr == 16'h0201;
  endsequence
  sequence osc_role;
    sys_loop_dco_sel_ff && sys_loop_enable_ff && !synth_standalone_ff;
  endsequence
  sequence synth_role;
    synth_standalone_ff && !sys_loop_enable_ff && !sys_loop_dco_sel_ff;
  endsequence
  AST_RD_VALID: assert property (reg_rd |=> reg_rvalid_ff)
    else $error("read not answered next cycle");
  AST_NO_RD_VALID: assert property (!reg_rd |=> !reg_rvalid_ff)
    else $error("read valid without a read");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 16'h01E8 |=>
    reg_rdata_ff == 8'h00 && !reg_hit_ff)
    else $error("unmapped read not refused");
  AST_OSC_ROLE: assert property (mode_wr ##0 !reg_wdata[6] |-> ##2 osc_role)
    else $error("oscillator role not applied");
  AST_SYNTH_ROLE: assert property (mode_wr ##0 reg_wdata[6] |-> ##2 synth_role)
    else $error("synthesizer role not applied");
  AST_INT_MODE: assert property (mode_wr ##0 !reg_wdata[7] |-> ##2
    analog_fb_ff.numer == 24'h0 && analog_fb_ff.denom == 24'h0)
    else $error("integer mode keeps a fraction");
  AST_FRAC_MODE: assert property (mode_wr ##0 reg_wdata[7] |-> ##2
    analog_fb_ff.denom == analog_cfg_ff.analog_denom)
    else $error("fractional mode lost denominator");
  AST_AINT: assert property (reg_wr && reg_addr == 16'h0200 |-> ##2
    analog_fb_ff.integer_div == $past(reg_wdata, 2))
    else $error("analog integer not applied");
  AST_L1INT_TOP: assert property (reg_wr && reg_addr == 16'h01E7 |-> ##2
    loop1_cfg_ff.loop1_fb_integer[31:24] == $past(reg_wdata, 2))
    else $error("loop integer top byte not applied");
endmodule : fdp_config_bank_monitor
bind fdp_config_bank fdp_config_bank_monitor mon (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
  .reg_rvalid_ff(reg_rvalid_ff), .reg_hit_ff(reg_hit_ff),
  .loop1_cfg_ff(loop1_cfg_ff), .analog_cfg_ff(analog_cfg_ff),
  .analog_fb_ff(analog_fb_ff), .sys_loop_dco_sel_ff(sys_loop_dco_sel_ff),
  .synth_standalone_ff(synth_standalone_ff),
  .sys_loop_enable_ff(sys_loop_enable_ff));

// >>> tb/fdp_config_bank_test.sv
// Self-checking bench for the divider configuration bank.
`timescale 1ns/1ns
module fdp_config_bank_test;
  import fdp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  fdp_byte_t reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  fdp_byte_t reg_rdata_ff;
  logic reg_rvalid_ff, reg_hit_ff, dco_sel, synth, sys_en, pd_err, conflict;
  fdp_loop1_cfg_s loop1_cfg_ff;
  fdp_analog_cfg_s analog_cfg_ff;
  fdp_feedback_s analog_fb_ff;
  fdp_byte_t [6:0] aux;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] offs [29] = '{16'h01E0, 16'h01E1, 16'h01E2, 16'h01E3,
    16'h01E4, 16'h01E5, 16'h01E6, 16'h01E7, 16'h01E9, 16'h01EA, 16'h01EB,
    16'h01EC, 16'h01ED, 16'h01EE, 16'h0200, 16'h0201, 16'h0202, 16'h0203,
    16'h0204, 16'h0205, 16'h0206, 16'h0208, 16'h0209, 16'h020A, 16'h020C,
    16'h020D, 16'h020E, 16'h020F, 16'h0210};
  fdp_byte_t rstv [29] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hBA, 8'h0F, 8'h00,
    8'h00, 8'h00, 8'hF0, 8'h33, 8'h00, 8'hA8, 8'h61, 8'h31, 8'hC0, 8'h75,
    8'h06, 8'h00, 8'h00, 8'h43, 8'h00, 8'h00, 8'h7D, 8'h06, 8'h80, 8'h0F,
    8'hF0, 8'h00};
  fdp_byte_t mask [29] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC0, 8'hFF,
    8'hBF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7E, 8'hBF, 8'hFF,
    8'hFF, 8'hF0};
  always #4 clk = ~clk;
  fdp_config_bank uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .reg_hit_ff(reg_hit_ff), .loop1_cfg_ff(loop1_cfg_ff),
    .analog_cfg_ff(analog_cfg_ff), .analog_fb_ff(analog_fb_ff),
    .sys_loop_dco_sel_ff(dco_sel), .synth_standalone_ff(synth),
    .sys_loop_enable_ff(sys_en), .prediv_range_err_ff(pd_err),
    .role_mode_conflict_ff(conflict), .analog_aux_ff(aux));
  function automatic fdp_byte_t pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction : pat
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input fdp_byte_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input fdp_byte_t e, input logic h);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(reg_rvalid_ff, 1'b1);
    check(reg_hit_ff, h);
    check(reg_rdata_ff, e);
  endtask : rd
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(synth, 1'b1);
    check(sys_en, 1'b0);
    check(loop1_cfg_ff.loop1_fb_integer, 32'h0000_0FBA);
    check(analog_fb_ff.integer_div, 8'h31);
    check(analog_fb_ff.numer, 24'h43_0000);
    check(analog_fb_ff.denom, 24'h7D_0000);
    check(dco_sel, 1'b0);
    check(pd_err, 1'b1);
    check(conflict, 1'b0);
    check(analog_cfg_ff.analog_role_select, 1'b1);
    check(analog_cfg_ff.fractional_modulator_enable, 1'b1);
    check(loop1_cfg_ff.loop1_fb_numer, 24'h33_F000);
    check(loop1_cfg_ff.loop1_fb_denom, 24'h61_A800);
    for (int i = 0; i < 29; i++)
      rd(offs[i], rstv[i], 1'b1);
    for (int i = 0; i < 29; i++)
      wr(offs[i], pat(offs[i]));
    for (int i = 0; i < 29; i++)
      rd(offs[i], pat(offs[i]) & mask[i], 1'b1);
    check(loop1_cfg_ff.loop1_fb_integer, {pat(16'h01E7), pat(16'h01E6),
      pat(16'h01E5), pat(16'h01E4)});
    check(loop1_cfg_ff.loop1_fb_denom, {pat(16'h01EE), pat(16'h01ED),
      pat(16'h01EC)});
    check(loop1_cfg_ff.loop1_fb_numer, {pat(16'h01EB), pat(16'h01EA),
      pat(16'h01E9)});
    check(analog_cfg_ff.analog_denom, {pat(16'h020A), pat(16'h0209),
      pat(16'h0208)});
    check(aux[0], pat(16'h0202));
    check(aux[1], pat(16'h0203) & mask[17]);
    check(aux[6], pat(16'h0210) & mask[28]);
    check(pd_err, 1'b0);
    wr(16'h01E8, 8'h77);
    rd(16'h01E8, 8'h00, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      wr(16'h0201, {m[1:0], 6'h00});
      @(negedge clk);
      check(dco_sel, !m[0]);
      check(sys_en, !m[0]);
      check(synth, m[0]);
      check(conflict, !m[0] && !m[1]);
      check(analog_fb_ff.numer, m[1] ? {pat(16'h0206), pat(16'h0205),
        pat(16'h0204)} : 24'h0);
      check(analog_fb_ff.integer_div, pat(16'h0200));
      check(analog_fb_ff.denom, m[1] ? {pat(16'h020A), pat(16'h0209),
        pat(16'h0208)} : 24'h0);
      check(analog_cfg_ff.analog_role_select, m[0]);
      check(analog_cfg_ff.fractional_modulator_enable, m[1]);
    end
    wr(16'h01E0, 8'h00);
    wr(16'h01E1, 8'h00);
    @(negedge clk);
    check(pd_err, 1'b1);
    wr(16'h01E0, 8'h01);
    @(negedge clk);
    check(pd_err, 1'b0);
    wr(16'h01E0, 8'hFF);
    wr(16'h01E1, 8'hFF);
    @(negedge clk);
    check(loop1_cfg_ff.ref0_prediv, 10'h3FF);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(loop1_cfg_ff.ref0_prediv, 10'h000);
    check(pd_err, 1'b1);
    check(synth, 1'b1);
    check(analog_fb_ff.integer_div, 8'h31);
    rd(16'h0201, 8'hC0, 1'b1);
    rd(16'h01E7, 8'h00, 1'b1);
    results();
  end
endmodule : fdp_config_bank_test
